// File: logic/scmc_pkg.sv
`default_nettype none
package scmc_pkg;

   // ==========================================================================
   // Timing base
   // ==========================================================================
   localparam int CLK_HZ         = 50_000_000;
   localparam int CLK_PERIOD_NS  = 20;

   // Oscillator rates. Both are modelled as tick enables derived from mclk.
   localparam int FAST_HZ_2M     = 2_000_000;
   localparam int FAST_HZ_4M     = 4_000_000;
   localparam int FAST_HZ_8M     = 8_000_000;
   localparam int SLOW_HZ        = 32_000;
   localparam int FAST_PER_2M    = CLK_HZ / FAST_HZ_2M;
   localparam int FAST_PER_4M    = CLK_HZ / FAST_HZ_4M;
   localparam int FAST_PER_8M    = CLK_HZ / FAST_HZ_8M;
   localparam int SLOW_PER       = CLK_HZ / SLOW_HZ;

   // Start-up times before an oscillator counts as stable, rounded up.
   localparam int FAST_STARTUP_NS  = 10_000;
   localparam int SLOW_STARTUP_NS  = 40_000;
   localparam int FAST_STARTUP_CYC = (FAST_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SLOW_STARTUP_CYC = (SLOW_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OSC_W            = 11;

   // ==========================================================================
   // Clock selection
   // ==========================================================================
   localparam int         SEL_W     = 3;
   localparam logic [2:0] SEL_SLOW  = 3'h7;
   localparam int         DIV_TAPS  = 7;
   localparam logic [1:0] FREQ_2M   = 2'h0;
   localparam logic [1:0] FREQ_4M   = 2'h1;
   localparam logic [1:0] FREQ_8M   = 2'h2;

   // ==========================================================================
   // Register map and fields
   // ==========================================================================
   localparam logic [11:0] REG_CTRL_OFF    = 12'h000;
   localparam logic [11:0] REG_FOSC_OFF    = 12'h004;
   localparam logic [11:0] REG_STAT_OFF    = 12'h008;
   localparam int          CTRL_SEL_LSB    = 5;
   localparam int          CTRL_FKEEP_BIT  = 1;
   localparam int          CTRL_SKEEP_BIT  = 0;
   localparam int          FOSC_FREQ_LSB   = 2;
   localparam int          FOSC_STABLE_BIT = 1;
   localparam int          FOSC_EN_BIT     = 0;
   localparam int          STAT_MODE_LSB   = 0;
   localparam int          STAT_PDF_BIT    = 3;
   localparam int          STAT_TO_BIT     = 4;
   localparam int          STAT_SSTAB_BIT  = 5;
   localparam int          STAT_HALT_BIT   = 6;
   localparam logic [2:0]  SEL_RST         = 3'h0;
   localparam logic        KEEP_RST        = 1'b0;
   localparam logic        FOSC_EN_RST     = 1'b1;
   localparam logic [1:0]  FOSC_FREQ_RST   = 2'h0;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef enum logic [2:0] {
      MODE_FAST, MODE_SLOW, MODE_SLEEP, MODE_IDLE_LOW, MODE_IDLE_DUAL, MODE_IDLE_HIGH
   } scmc_mode_t;

   typedef struct packed {
      logic sysClk;
      logic fastClk;
      logic slowClk;
      logic slowOsc;
   } scmc_clk_t;

endpackage : scmc_pkg
`default_nettype wire

// File: logic/scmc_osc.sv
`timescale 1ns/1ps
`default_nettype none
module scmc_osc #(
   parameter int PW = 11
) (
   input  wire logic          mclk,
   input  wire logic          rst,
   input  wire logic          enable,
   input  wire logic [PW-1:0] period,
   input  wire logic [PW-1:0] startup,
   output logic               tick,
   output logic               stable
);

   logic [PW-1:0] perLast_r;
   logic [PW-1:0] phase_r;
   logic [PW-1:0] startCnt_r;
   logic          stable_r;
   logic          restart;

   // A disable or a new rate restarts the start-up wait, so no tick of an
   // unsettled oscillator ever leaves this module.
   assign restart = !enable || (period != perLast_r);

   // Remember the rate in use to notice a change.
   always_ff @(posedge mclk) begin
      if (rst) begin
         perLast_r <= '0;
      end else begin
         perLast_r <= period;
      end
   end

   // Start-up counter and stable flag.
   always_ff @(posedge mclk) begin
      if (rst || restart) begin
         startCnt_r <= '0;
         stable_r   <= 1'b0;
      end else if (!stable_r) begin
         if (startCnt_r == startup - 1'b1) begin
            stable_r <= 1'b1;
         end else begin
            startCnt_r <= startCnt_r + 1'b1;
         end
      end
   end

   // Phase counter that paces the ticks once stable.
   always_ff @(posedge mclk) begin
      if (rst || restart || !stable_r) begin
         phase_r <= '0;
      end else if (phase_r == period - 1'b1) begin
         phase_r <= '0;
      end else begin
         phase_r <= phase_r + 1'b1;
      end
   end

   assign tick   = stable_r && !restart && (phase_r == period - 1'b1);
   assign stable = stable_r && !restart;

endmodule : scmc_osc
`default_nettype wire

// File: logic/scmc_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module scmc_prescaler #(
   parameter int TAPS = 7
) (
   input  wire logic            mclk,
   input  wire logic            rst,
   input  wire logic            tickIn,
   output logic [TAPS-1:0]      taps
);

   logic [TAPS-2:0] cnt_r;

   // Ripple count of input ticks; all taps pulse together when it wraps.
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (tickIn) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // Tap i pulses on every 2**i-th input tick.
   genvar i;
   generate
      for (i = 0; i < TAPS; i++) begin : g_tap
         if (i == 0) begin : g_first
            assign taps[i] = tickIn;
         end else begin : g_rest
            assign taps[i] = tickIn & (&cnt_r[i-1:0]);
         end
      end
   endgenerate

endmodule : scmc_prescaler
`default_nettype wire

// File: logic/scmc_top.sv
// Function
// - Fast mode: codes 0 to 6 give high clock divided by 1 to 64.
// - High clock comes from fast RC oscillator, low clock from slow one.
// - Code 7 selects slow mode, CPU running on the low clock.
// - After moving to low clock, fast oscillator follows its enable bit.
// - In slow mode with code 7 still selected the high clock follows the enable bit only.
// - Running modes keep CPU, low clock and slow oscillator active.
// - Halt with both keeps low enters sleep, stopping CPU and clocks.
// - Slow oscillator keeps running in sleep for the watchdog.
// - Halt with only slow keep: low-only idle, system clock if code 7.
// - Halt with both keeps: dual idle, all clocks stay running.
// - Halt with only fast keep: high-only idle, system clock if fast code.
// - Exactly six modes: two running, four with the CPU off.
// - New high clock used only after the stable flag is set.
// - Entering sleep or idle sets power-down, clears timeout unless one arrives in the same cycle, clears watchdog.
// - Switch to slow mode completes only with slow oscillator stable.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module scmc_top #(
   parameter int AW = 12
) (
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [AW-1:0]              paddr,
   input  wire logic [31:0]                pwdata,
   output logic [31:0]                     prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       haltReq,
   input  wire logic                       wakeReq,
   input  wire logic                       wdtTimeout,
   output logic                            cpuRun,
   output scmc_pkg::scmc_clk_t             clkEn,
   output logic [scmc_pkg::DIV_TAPS-1:0]   fastDivEn,
   output scmc_pkg::scmc_mode_t            mode,
   output logic                            powerDownFlag,
   output logic                            watchdogTimeoutFlag,
   output logic                            wdtClear
);
   import scmc_pkg::*;

   // ==========================================================================
   // State
   // ==========================================================================
   logic [SEL_W-1:0]    sysClkSelect_r;
   logic [SEL_W-1:0]    activeSel_r;
   logic                fastOscHaltKeep_r;
   logic                slowOscHaltKeep_r;
   logic                fastOscEn_r;
   logic [1:0]          fastFreq_r;
   logic                halt_r;
   logic                pdf_r;
   logic                to_r;
   logic                wdtClear_r;
   logic [31:0]         prdata_r;
   scmc_mode_t          mode_r;
   scmc_mode_t          modeNow;
   logic [OSC_W-1:0]    fastPeriod;
   logic                fastRun;
   logic                fastTick;
   logic                fastStable;
   logic                slowTick;
   logic                slowStable;
   logic                activeSlow;
   logic                adopt;
   logic                crossAdopt;
   logic                sysOn;
   logic                sysSrc;
   logic                haltTake;
   logic                wrEn;
   logic                unmapped;
   logic [31:0]         readVal;
   logic [DIV_TAPS-1:0] taps;

   // ==========================================================================
   // Oscillators
   // ==========================================================================
   // Rate of the fast oscillator from the frequency field; code 3 is 2 MHz.
   always_comb begin
      case (fastFreq_r)
         FREQ_4M: fastPeriod = OSC_W'(FAST_PER_4M);
         FREQ_8M: fastPeriod = OSC_W'(FAST_PER_8M);
         default: fastPeriod = OSC_W'(FAST_PER_2M);
      endcase
   end

   // Fast oscillator runs while halted only if kept; while running it runs
   // when the active or requested source needs it, or on its enable bit.
   assign fastRun = halt_r ? fastOscHaltKeep_r
                  : ((activeSel_r != SEL_SLOW) || (sysClkSelect_r != SEL_SLOW)
                     || fastOscEn_r);

   scmc_osc #(.PW(OSC_W)) u_fastOsc (
      .mclk    (mclk),
      .rst     (rst),
      .enable  (fastRun),
      .period  (fastPeriod),
      .startup (OSC_W'(FAST_STARTUP_CYC)),
      .tick    (fastTick),
      .stable  (fastStable)
   );

   // The slow oscillator never stops; the watchdog depends on it.
   scmc_osc #(.PW(OSC_W)) u_slowOsc (
      .mclk    (mclk),
      .rst     (rst),
      .enable  (1'b1),
      .period  (OSC_W'(SLOW_PER)),
      .startup (OSC_W'(SLOW_STARTUP_CYC)),
      .tick    (slowTick),
      .stable  (slowStable)
   );

   scmc_prescaler #(.TAPS(DIV_TAPS)) u_prescaler (
      .mclk   (mclk),
      .rst    (rst),
      .tickIn (fastTick),
      .taps   (taps)
   );

   // ==========================================================================
   // System clock source switching
   // ==========================================================================
   // A change is adopted only at a boundary: the divider wrap for a fast
   // target, where every tap pulses, or a slow tick for a slow target. A
   // fast target never wraps until its oscillator is stable.
   assign activeSlow = (activeSel_r == SEL_SLOW);
   always_comb begin
      adopt = 1'b0;
      if ((sysClkSelect_r != activeSel_r) && !halt_r) begin
         if (sysClkSelect_r == SEL_SLOW) begin
            adopt = slowTick && slowStable;
         end else begin
            adopt = taps[DIV_TAPS-1];
         end
      end
   end

   // Crossing between oscillators drops the adopting pulse, so the first new
   // period is a whole one; this costs one period of latency.
   assign crossAdopt = adopt && ((sysClkSelect_r == SEL_SLOW) != activeSlow);

   always_ff @(posedge mclk) begin
      if (rst) begin
         activeSel_r <= SEL_RST;
      end else if (adopt) begin
         activeSel_r <= sysClkSelect_r;
      end
   end

   // While halted the system clock lives on only if its source is kept.
   assign sysOn  = !halt_r || (activeSlow ? slowOscHaltKeep_r : fastOscHaltKeep_r);
   assign sysSrc = activeSlow ? slowTick : taps[activeSel_r];

   assign clkEn.sysClk  = sysOn && sysSrc && !crossAdopt;
   assign clkEn.fastClk = fastTick;
   assign clkEn.slowClk = slowTick && (!halt_r || slowOscHaltKeep_r);
   assign clkEn.slowOsc = slowTick;
   assign fastDivEn     = taps;

   // ==========================================================================
   // Halt, wake and operating mode
   // ==========================================================================
   assign haltTake = haltReq && !halt_r;

   always_ff @(posedge mclk) begin
      if (rst) begin
         halt_r <= 1'b0;
      end else if (haltTake) begin
         halt_r <= 1'b1;
      end else if (wakeReq) begin
         halt_r <= 1'b0;
      end
   end

   // Six modes from the halt state, the active source and the two keep bits.
   always_comb begin
      if (!halt_r) begin
         modeNow = activeSlow ? MODE_SLOW : MODE_FAST;
      end else begin
         case ({fastOscHaltKeep_r, slowOscHaltKeep_r})
            2'b00:   modeNow = MODE_SLEEP;
            2'b01:   modeNow = MODE_IDLE_LOW;
            2'b11:   modeNow = MODE_IDLE_DUAL;
            default: modeNow = MODE_IDLE_HIGH;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_r <= MODE_FAST;
      end else begin
         mode_r <= modeNow;
      end
   end

   // Power-down flag: halt entry sets it, a write of one clears it; the set
   // wins when both come together.
   always_ff @(posedge mclk) begin
      if (rst) begin
         pdf_r <= 1'b0;
      end else if (haltTake) begin
         pdf_r <= 1'b1;
      end else if (wrEn && (paddr == AW'(REG_STAT_OFF)) && pwdata[STAT_PDF_BIT]) begin
         pdf_r <= 1'b0;
      end
   end

   // Timeout flag: the watchdog sets it, halt entry clears it; a timeout in
   // the same cycle is kept rather than lost.
   always_ff @(posedge mclk) begin
      if (rst) begin
         to_r <= 1'b0;
      end else if (wdtTimeout) begin
         to_r <= 1'b1;
      end else if (haltTake) begin
         to_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wdtClear_r <= 1'b0;
      end else begin
         wdtClear_r <= haltTake;
      end
   end

   assign cpuRun              = !halt_r;
   assign mode                = mode_r;
   assign powerDownFlag       = pdf_r;
   assign watchdogTimeoutFlag = to_r;
   assign wdtClear            = wdtClear_r;

   // ==========================================================================
   // APB slave
   // ==========================================================================
   assign pready   = 1'b1;
   assign wrEn     = psel && penable && pwrite && !unmapped;
   assign pslverr  = psel && penable && unmapped;
   assign prdata   = prdata_r;

   // Address decode and read data.
   always_comb begin
      readVal  = 32'h0000_0000;
      unmapped = 1'b0;
      if (paddr == AW'(REG_CTRL_OFF)) begin
         readVal[CTRL_SEL_LSB +: SEL_W] = sysClkSelect_r;
         readVal[CTRL_FKEEP_BIT]        = fastOscHaltKeep_r;
         readVal[CTRL_SKEEP_BIT]        = slowOscHaltKeep_r;
      end else if (paddr == AW'(REG_FOSC_OFF)) begin
         readVal[FOSC_FREQ_LSB +: 2]    = fastFreq_r;
         readVal[FOSC_STABLE_BIT]       = fastStable;
         readVal[FOSC_EN_BIT]           = fastOscEn_r;
      end else if (paddr == AW'(REG_STAT_OFF)) begin
         readVal[STAT_MODE_LSB +: 3]    = modeNow;
         readVal[STAT_PDF_BIT]          = pdf_r;
         readVal[STAT_TO_BIT]           = to_r;
         readVal[STAT_SSTAB_BIT]        = slowStable;
         readVal[STAT_HALT_BIT]         = halt_r;
      end else begin
         unmapped = 1'b1;
      end
   end

   // Read data is captured in the setup cycle so it comes from a flop.
   always_ff @(posedge mclk) begin
      if (rst) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= readVal;
      end
   end

   // Control register writes.
   always_ff @(posedge mclk) begin
      if (rst) begin
         sysClkSelect_r    <= SEL_RST;
         fastOscHaltKeep_r <= KEEP_RST;
         slowOscHaltKeep_r <= KEEP_RST;
      end else if (wrEn && (paddr == AW'(REG_CTRL_OFF))) begin
         sysClkSelect_r    <= pwdata[CTRL_SEL_LSB +: SEL_W];
         fastOscHaltKeep_r <= pwdata[CTRL_FKEEP_BIT];
         slowOscHaltKeep_r <= pwdata[CTRL_SKEEP_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         fastOscEn_r <= FOSC_EN_RST;
         fastFreq_r  <= FOSC_FREQ_RST;
      end else if (wrEn && (paddr == AW'(REG_FOSC_OFF))) begin
         fastOscEn_r <= pwdata[FOSC_EN_BIT];
         fastFreq_r  <= pwdata[FOSC_FREQ_LSB +: 2];
      end
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   logic [OSC_W-1:0] slowGap_r;
   logic [OSC_W-1:0] sysGap_r;

   // Cycles since the last slow tick and since the last system clock pulse.
   always_ff @(posedge mclk) begin
      if (rst) begin
         slowGap_r <= '0;
         sysGap_r  <= '1;
      end else begin
         slowGap_r <= clkEn.slowOsc ? '0 : (slowGap_r + {{(OSC_W-1){1'b0}}, ~&slowGap_r});
         sysGap_r  <= clkEn.sysClk ? '0 : (sysGap_r + {{(OSC_W-1){1'b0}}, ~&sysGap_r});
      end
   end

   fast_div_sel_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn.sysClk && !activeSlow |-> fastDivEn[activeSel_r])
      else $error("System clock pulse without its divider tap.");

   fast_src_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn.fastClk |-> fastRun && fastStable)
      else $error("High clock ticked while its oscillator was off.");

   slow_src_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn.sysClk && activeSlow |-> clkEn.slowOsc && slowStable)
      else $error("Slow system clock not taken from the slow oscillator.");

   slow_fast_en_a: assert property (@(posedge mclk) disable iff (rst)
      cpuRun && activeSlow && (sysClkSelect_r == SEL_SLOW) && !fastOscEn_r
      |-> !clkEn.fastClk && !fastDivEn[DIV_TAPS-1])
      else $error("High clock ran in slow mode with its enable low.");

   fast_keep_a: assert property (@(posedge mclk) disable iff (rst)
      cpuRun && fastOscEn_r |-> fastRun)
      else $error("Enabled fast oscillator stopped while running.");

   running_clocks_a: assert property (@(posedge mclk) disable iff (rst)
      cpuRun |-> (clkEn.slowClk == clkEn.slowOsc))
      else $error("Low clock gated while the CPU runs.");

   sleep_stops_a: assert property (@(posedge mclk) disable iff (rst)
      modeNow == MODE_SLEEP
      |-> !clkEn.sysClk && !clkEn.fastClk && !clkEn.slowClk && !cpuRun)
      else $error("A clock ran in sleep mode.");

   sleep_wdt_a: assert property (@(posedge mclk) disable iff (rst)
      slowStable && (modeNow == MODE_SLEEP) |-> slowGap_r < OSC_W'(SLOW_PER))
      else $error("Slow oscillator stalled in sleep.");

   idle_low_a: assert property (@(posedge mclk) disable iff (rst)
      modeNow == MODE_IDLE_LOW
      |-> !clkEn.fastClk && (clkEn.slowClk == clkEn.slowOsc) && (!clkEn.sysClk || activeSlow))
      else $error("Low-only idle clocks wrong.");

   idle_dual_a: assert property (@(posedge mclk) disable iff (rst)
      modeNow == MODE_IDLE_DUAL |-> fastRun && (clkEn.slowClk == clkEn.slowOsc)
      && (clkEn.sysClk == sysSrc))
      else $error("Dual idle stopped a clock.");

   idle_high_a: assert property (@(posedge mclk) disable iff (rst)
      modeNow == MODE_IDLE_HIGH |-> fastRun && !clkEn.slowClk && (!clkEn.sysClk || !activeSlow))
      else $error("High-only idle clocks wrong.");

   mode_cpu_a: assert property (@(posedge mclk) disable iff (rst)
      (cpuRun == ((modeNow == MODE_FAST) || (modeNow == MODE_SLOW))) ##1 (mode == $past(modeNow)))
      else $error("Mode and CPU state disagree.");

   stable_first_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(fastRun) |-> !clkEn.fastClk [*8])
      else $error("High clock used before the oscillator settled.");

   halt_flags_a: assert property (@(posedge mclk) disable iff (rst)
      haltTake |=> powerDownFlag && wdtClear && !cpuRun
      && (!watchdogTimeoutFlag || $past(wdtTimeout)))
      else $error("Halt entry did not update the power-down flags.");

   slow_ready_a: assert property (@(posedge mclk) disable iff (rst)
      !activeSlow ##1 activeSlow |-> $past(slowStable))
      else $error("Switched to slow mode before the slow oscillator settled.");

   no_runt_a: assert property (@(posedge mclk) disable iff (rst)
      clkEn.sysClk |-> sysGap_r >= OSC_W'(FAST_PER_8M - 1))
      else $error("Runt system clock period.");

endmodule : scmc_top
`default_nettype wire

// File: verification/scmc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// CPU core stand-in
// ============================================================================
module scmc_cpu_model (
   input  wire logic mclk,
   input  wire logic haltCmd,
   input  wire logic wakeCmd,
   output logic      haltReq,
   output logic      wakeReq
);
   logic cmd_r = 1'b0;
   initial haltReq = 1'b0;
   initial wakeReq = 1'b0;
   // A held command gives one single-cycle request, as a halt instruction would.
   always @(posedge mclk) begin
      cmd_r   <= haltCmd | wakeCmd;
      haltReq <= haltCmd & ~cmd_r;
      wakeReq <= wakeCmd & ~cmd_r;
   end
endmodule : scmc_cpu_model
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Bench
// ============================================================================
module tb_top;
   import scmc_pkg::*;
   logic mclk, rst = 1, psel = 0, penable = 0, pwrite = 0, wdt = 0, hc = 0, wc = 0;
   logic pready, pslverr, haltReq, wakeReq, cpuRun, power_down_flag, tof, wclr, perr, fk, sk, en, cnt = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [6:0] divEn;
   logic [2:0] sel;
   scmc_clk_t clkEn;
   scmc_mode_t mode;
   int fails = 0, comparisons = 0, seed = 21, nS, nF, nL, nO, nD, nW = 0;
   scmc_top dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .haltReq(haltReq), .wakeReq(wakeReq), .wdtTimeout(wdt), .cpuRun(cpuRun),
      .clkEn(clkEn), .fastDivEn(divEn), .mode(mode), .powerDownFlag(power_down_flag),
      .watchdogTimeoutFlag(tof), .wdtClear(wclr));
   scmc_cpu_model cpu (.mclk(mclk), .haltCmd(hc), .wakeCmd(wc), .haltReq(haltReq),
      .wakeReq(wakeReq));
   initial begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end
   // Tick counts over a window tell which clocks are alive in each mode.
   // Watchdog clear pulses are counted over the whole run, one per halt.
   always @(posedge mclk) begin
      nW += wclr;
      if (cnt) begin
         nS += clkEn.sysClk;
         nF += clkEn.fastClk;
         nL += clkEn.slowClk;
         nO += clkEn.slowOsc;
         nD += divEn[DIV_TAPS-1];
      end
   end
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge mclk);
      penable <= 1;
      // The wait ends when pready reads 1; only a hang is left to the bench watchdog.
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask : chk
   task conclude;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   // Cut a hang short well past the expected run of about 50k cycles.
   initial begin
      #1_600_000;
      fails++;
      conclude();
   end
   initial begin
      repeat (2) @(posedge mclk);
      rst <= 0;
      apb(0, REG_CTRL_OFF, 0);
      chk(rd, 0);
      apb(0, REG_FOSC_OFF, 0);
      chk(rd[0], FOSC_EN_RST);
      apb(1, 12'hFF0, 0);
      chk(perr, 1);
      // Keep bits walk all four halt modes, once for a fast and once for
      // the slow selection; the slow passes with odd index drop the enable.
      for (int i = 0; i < 8; i++) begin
         sel = i[2] ? 3'h7 : 3'($unsigned($random(seed)) % 7);
         fk = i[1];
         sk = i[0];
         en = ~(i[2] & i[0]);
         apb(1, REG_FOSC_OFF, {28'h0, i[1:0], 1'b0, en});
         apb(1, REG_CTRL_OFF, {24'h0, sel, 3'h0, fk, sk});
         repeat (2000) @(posedge mclk);
         {nS, nF, nL, nO, nD} = 0;
         cnt <= 1;
         repeat (2000) @(posedge mclk);
         cnt <= 0;
         chk(mode, sel == 7 ? MODE_SLOW : MODE_FAST);
         chk({nS > 0, nL > 0, nO > 0}, 3'b111);
         chk({nF > 0, nD > 0}, {en, en});
         apb(0, REG_FOSC_OFF, 0);
         chk(rd[3:0], {i[1:0], en, en});
         wdt <= 1;
         @(posedge mclk) wdt <= 0;
         @(posedge mclk);
         chk(tof, 1);
         hc <= 1;
         @(posedge mclk) hc <= 0;
         repeat (4) @(posedge mclk);
         chk({cpuRun, power_down_flag, tof}, 3'b010);
         chk(nW, i + 1);
         chk(mode, fk ? (sk ? MODE_IDLE_DUAL : MODE_IDLE_HIGH)
                      : (sk ? MODE_IDLE_LOW : MODE_SLEEP));
         {nS, nF, nL, nO} = 0;
         cnt <= 1;
         repeat (2000) @(posedge mclk);
         cnt <= 0;
         chk(nS > 0, fk & sk | sk & sel == 7 | fk & ~sk & sel != 7);
         chk({nF > 0, nL > 0, nO > 0}, {fk, sk, 1'b1});
         wc <= 1;
         @(posedge mclk) wc <= 0;
         repeat (4) @(posedge mclk);
         chk(cpuRun, 1);
         apb(1, REG_STAT_OFF, 32'h8);
         @(posedge mclk);
         chk(power_down_flag, 0);
      end
      conclude();
   end
endmodule : tb_top
`default_nettype wire
